// [hdl/external_address_attribute_decode.sv]
// Address attribute decoder of an external memory port: four APB registers, each
// steering one attribute or row strobe pin from the address and space of an access.
// Assumes the access request comes from logic on clk and software sets every
// memory type field to SRAM or DRAM before the port is used.
`timescale 1ns/1ps

module external_address_attribute_decode
    import area_attr_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [PADDR_W-1:0]     paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   ext_valid,
    input  wire logic [1:0]             ext_space,
    input  wire logic [EXT_ADDR_W-1:0]  ext_addr,
    input  wire logic                   ext_internal,
    output logic      [NUM_AREAS-1:0]   attribute_or_row_strobe_pin,
    output logic      [NUM_AREAS-1:0]   row_strobe_mode,
    output logic                        access_dram,
    output logic                        default_area
);

    // =========================================================================
    // Decode helpers
    // =========================================================================

    // Maps a bus address to a register index; bit 2 of the result flags a hit.
    function automatic logic [2:0] reg_index(input logic [PADDR_W-1:0] a);
        logic [2:0] r;
        r = 3'h0;
        if (a == AREA0_OFFSET)
            r = 3'h4;
        else if (a == AREA1_OFFSET)
            r = 3'h5;
        else if (a == AREA2_OFFSET)
            r = 3'h6;
        else if (a == AREA3_OFFSET)
            r = 3'h7;
        return r;
    endfunction

    // Tells whether an access hits the area that one register describes.
    function automatic logic area_hit(input logic [REG_W-1:0]      cfg,
                                      input logic [1:0]            space,
                                      input logic [EXT_ADDR_W-1:0] addr,
                                      input logic                  internal);
        logic [CMP_BITS-1:0] mask;
        logic [3:0]          width;
        logic                space_on;
        mask     = '0;
        width    = cfg[CMP_W_HI:CMP_W_LO];
        space_on = 1'b0;
        // Widths above the largest are reserved and compare all bits.
        if (width > CMP_W_MAX)
            width = CMP_W_MAX;
        for (int k = 0; k < CMP_BITS; k++)
        begin
            mask[CMP_BITS-1-k] = (4'(k) < width);
        end
        if (space == SPACE_Y)
            space_on = cfg[Y_EN_BIT];
        else if (space == SPACE_X)
            space_on = cfg[X_EN_BIT];
        else if (space == SPACE_PROGRAM)
            space_on = cfg[P_EN_BIT];
        // Width zero needs an external address.
        if (width == CMP_W_NONE)
            return space_on && !internal;
        // Upper address bits compared under the width mask.
        return space_on && (((cfg[CMP_ADDR_HI:CMP_ADDR_LO] ^ addr[EXT_ADDR_W-1:EXT_ADDR_W-CMP_BITS]) & mask) == '0);
    endfunction

    // =========================================================================
    // APB register file
    // =========================================================================

    logic [REG_W-1:0]     area_reg [NUM_AREAS];
    logic [2:0]           bus_index;
    logic                 bus_write;

    // Decode of the current bus address and write strobe in the access phase.
    assign bus_index = reg_index(paddr);
    assign bus_write = psel && penable && pwrite && bus_index[2];
    assign pready    = 1'b1;
    assign pslverr   = psel && penable && !bus_index[2];

    generate
        for (genvar g = 0; g < NUM_AREAS; g++)
        begin : g_area
            always_ff @(posedge clk)
            begin
                if (!reset_n)
                    area_reg[g] <= REG_RESET;
                else if (bus_write && bus_index[1:0] == 2'(g))
                    area_reg[g] <= pwdata[REG_W-1:0] & REG_WRITE_MASK; // Reserved bit 6 stays zero.
            end
        end
    endgenerate

    // Read data is captured in the setup phase so it stands during the access phase.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            prdata <= 32'h00000000;
        else if (psel && !penable)
        begin
            if (bus_index[2] && !pwrite)
                prdata <= {8'h00, area_reg[bus_index[1:0]]};
            else
                prdata <= 32'h00000000;
        end
    end

    // =========================================================================
    // Area match and pin drive
    // =========================================================================

    logic [NUM_AREAS-1:0] hit;
    logic [NUM_AREAS-1:0] pol;
    logic [NUM_AREAS-1:0] is_dram;
    logic                 next_dram;

    // Per register hit only for a valid, enabled, matching access.
    generate
        for (genvar g = 0; g < NUM_AREAS; g++)
        begin : g_hit
            assign hit[g]     = ext_valid && area_hit(area_reg[g], ext_space, ext_addr, ext_internal);
            assign pol[g]     = area_reg[g][POL_BIT];
            assign is_dram[g] = (area_reg[g][TYPE_HI:TYPE_LO] == TYPE_DRAM);
        end
    endgenerate

    // Lowest matching register decides the memory type.
    always_comb
    begin
        next_dram = 1'b0;
        for (int k = NUM_AREAS - 1; k >= 0; k--)
        begin
            if (hit[k])
                next_dram = is_dram[k];
        end
    end

    // Pin level follows the polarity bit.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            attribute_or_row_strobe_pin <= '1;
        else
            attribute_or_row_strobe_pin <= ~(hit ^ pol);
    end

    // DRAM type marks the pin as a row address strobe.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            row_strobe_mode <= '0;
        else
            row_strobe_mode <= is_dram;
    end

    // Default area accesses run as SRAM.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            access_dram  <= 1'b0;
            default_area <= 1'b0;
        end
        else
        begin
            access_dram  <= next_dram;
            default_area <= ext_valid && (hit == '0);
        end
    end

    // =========================================================================
    // Checks
    // =========================================================================

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence y_access_off;
        ext_valid && ext_space == SPACE_Y && !area_reg[0][Y_EN_BIT];
    endsequence

    sequence pin_idle;
        attribute_or_row_strobe_pin[0] == !$past(pol[0]);
    endsequence

    y_gate_a: assert property (y_access_off |=> pin_idle)
        else $error("Pin asserted for Y access with Y compare disabled.");

    x_gate_a: assert property (ext_space == SPACE_X && !area_reg[1][X_EN_BIT] |=>
        attribute_or_row_strobe_pin[1] == !$past(pol[1]))
        else $error("Pin asserted for X access with X compare disabled.");

    prog_gate_a: assert property (ext_space == SPACE_PROGRAM && !area_reg[2][P_EN_BIT] |=>
        attribute_or_row_strobe_pin[2] == !$past(pol[2]))
        else $error("Pin asserted for program access with program compare disabled.");

    pin_polarity_a: assert property (hit[3] |=> attribute_or_row_strobe_pin[3] == $past(pol[3]))
        else $error("Pin level on a hit does not follow polarity.");

    type_encode_a: assert property (hit[0] && area_reg[0][TYPE_HI:TYPE_LO] == TYPE_SRAM |=> !access_dram)
        else $error("SRAM area reported as DRAM.");

    row_strobe_a: assert property (##1 row_strobe_mode[1] == $past(is_dram[1]))
        else $error("Row strobe mode does not follow memory type.");

    default_sram_a: assert property (ext_valid && hit == '0 |=> default_area && !access_dram)
        else $error("Default area access not treated as SRAM.");

    reset_clear_a: assert property ($rose(reset_n) |-> area_reg[0] == REG_RESET && area_reg[3] == REG_RESET
        && attribute_or_row_strobe_pin == '1)
        else $error("Registers or pins not cleared by reset.");

    // Width zero keeps internal addresses off.
    width_zero_a: assert property (ext_internal && area_reg[0][CMP_W_HI:CMP_W_LO] == CMP_W_NONE |-> !hit[0])
        else $error("Width zero area hit an internal address.");

    hit_valid_a: assert property (!ext_valid |=> attribute_or_row_strobe_pin == ~$past(pol))
        else $error("Pin asserted without an access.");

endmodule

// [hdl/area_attr_pkg.sv]
// Constants for the external area attribute decoder: register map, field layout,
// encodings of memory type and memory space.
// Assumes a 32-bit APB with byte addresses and a 24-bit external address bus.
package area_attr_pkg;

    // Register map, one aligned word per area attribute register.
    localparam int          NUM_AREAS       = 4;
    localparam int          PADDR_W         = 8;
    localparam logic [7:0]  AREA0_OFFSET    = 8'h00;
    localparam logic [7:0]  AREA1_OFFSET    = 8'h04;
    localparam logic [7:0]  AREA2_OFFSET    = 8'h08;
    localparam logic [7:0]  AREA3_OFFSET    = 8'h0C;

    // Field layout of one area attribute register.
    localparam int          REG_W           = 24;
    localparam int          CMP_ADDR_HI     = 23;
    localparam int          CMP_ADDR_LO     = 12;
    localparam int          CMP_W_HI        = 11;
    localparam int          CMP_W_LO        = 8;
    localparam int          Y_EN_BIT        = 5;
    localparam int          X_EN_BIT        = 4;
    localparam int          P_EN_BIT        = 3;
    localparam int          POL_BIT         = 2;
    localparam int          TYPE_HI         = 1;
    localparam int          TYPE_LO         = 0;
    localparam logic [23:0] REG_WRITE_MASK  = 24'hFFFFBF;
    localparam logic [23:0] REG_RESET       = 24'h000000;

    // Compare address geometry.
    localparam int          EXT_ADDR_W      = 24;
    localparam int          CMP_BITS        = 12;
    localparam logic [3:0]  CMP_W_MAX       = 4'hC;
    localparam logic [3:0]  CMP_W_NONE      = 4'h0;

    // Memory type encodings.
    localparam logic [1:0]  TYPE_SRAM       = 2'h1;
    localparam logic [1:0]  TYPE_DRAM       = 2'h2;

    // Memory space of an external access.
    typedef enum logic [1:0]
    {
        SPACE_PROGRAM = 2'b00,
        SPACE_X       = 2'b01,
        SPACE_Y       = 2'b10,
        SPACE_NONE    = 2'b11
    } space_e;

endpackage

// [sim/external_memory_model.sv]
// Far-side memory model: counts the cycles that open a DRAM row.
// Assumes the decoder outputs are registered on clk.
`timescale 1ns/1ps

module external_memory_model
(
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic dram_access,
    output int        dram_cycles
);
    // row strobe only on DRAM
    // A DRAM access opens a row; default-area cycles never do.
    always @(posedge clk)
        if (reset_n !== 1'b1)
            dram_cycles <= 0;
        else if (dram_access === 1'b1)
            dram_cycles <= dram_cycles + 1;
endmodule

// [sim/external_address_attribute_decode_bench.sv]
// Bench for the area attribute decoder: APB master, random accesses, reference model.
// Assumes zero-wait APB and decode outputs one edge after the access inputs.
`timescale 1ns/1ps

module external_address_attribute_decode_bench
    import area_attr_pkg::*;
();
    logic                  clk, reset_n, psel, penable, pwrite, ext_valid, ext_internal;
    logic                  pready, pslverr, rd_err, access_dram, default_area;
    logic [PADDR_W-1:0]    paddr;
    logic [31:0]           pwdata, prdata, rd_data, lfsr, d;
    logic [1:0]            ext_space;
    logic [EXT_ADDR_W-1:0] ext_addr;
    logic [NUM_AREAS-1:0]  pins, row_mode;
    logic [23:0]           regs [NUM_AREAS];
    logic [9:0]            exp_q [$];
    int                    num_errors, total_checks, cycles, dram_cycles, dram_expected;

    external_address_attribute_decode dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_valid(ext_valid), .ext_space(ext_space), .ext_addr(ext_addr),
        .ext_internal(ext_internal), .attribute_or_row_strobe_pin(pins), .row_strobe_mode(row_mode),
        .access_dram(access_dram), .default_area(default_area));
    external_memory_model mem (.clk(clk), .reset_n(reset_n), .dram_access(access_dram),
        .dram_cycles(dram_cycles));

    // =====================================================
    // Clock, timeout and shared tasks
    // The clock toggles every 20 ns; the counter cuts a hang short.
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            close_out();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expected);
        total_checks++;
        if (seen !== expected)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, expected, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // One APB transfer; read data and error are taken at the pready edge.
    task automatic apb(input logic wr, input logic [PADDR_W-1:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // =====================================================
    // Reference decode model
    // Expected {pins, row mode, dram, default} for one sampled access.
    function automatic logic [9:0] model(input logic v, input logic [1:0] sp, input logic [23:0] ad,
                                         input logic inr);
        logic [3:0] h, p, m;
        logic       dr;
        int         w;
        dr = 1'b0;
        for (int i = NUM_AREAS - 1; i >= 0; i--)
        begin
            w = (regs[i][CMP_W_HI:CMP_W_LO] > CMP_BITS) ? CMP_BITS : regs[i][CMP_W_HI:CMP_W_LO];
            h[i] = v & ((sp == SPACE_Y) ? regs[i][Y_EN_BIT] : (sp == SPACE_X) ? regs[i][X_EN_BIT]
                 : (sp == SPACE_PROGRAM) ? regs[i][P_EN_BIT] : 1'b0);
            if (w == 0 && inr)
                h[i] = 1'b0;
            for (int k = 0; k < w; k++)
                if (ad[23 - k] != regs[i][23 - k])
                    h[i] = 1'b0;
            p[i] = h[i] ? regs[i][POL_BIT] : ~regs[i][POL_BIT];
            m[i] = regs[i][TYPE_HI:TYPE_LO] == TYPE_DRAM;
            if (h[i])
                dr = m[i];
        end
        return {p, m, dr, v & (h == 4'h0)};
    endfunction

    // Each edge drives a new access and checks the one sampled an edge earlier.
    task automatic access(input int n);
        logic [9:0] e;
        for (int j = 0; j < n + 2; j++)
        begin
            @(posedge clk);
            if (exp_q.size() == 2)
                check("decode outputs", {pins, row_mode, access_dram, default_area}, exp_q.pop_front());
            lfsr = next_rand(lfsr);
            d = {8'h00, lfsr[5] ? regs[lfsr[7:6]][23:12] : lfsr[31:20], lfsr[19:8]};
            e = model(j < n && lfsr[1:0] != 2'h0, lfsr[3:2], d[23:0], lfsr[4]);
            dram_expected += e[1];
            exp_q.push_back(e);
            ext_valid <= j < n && lfsr[1:0] != 2'h0;
            ext_space <= lfsr[3:2];
            ext_internal <= lfsr[4];
            ext_addr <= d[23:0];
        end
        exp_q.delete();
    endtask

    // =====================================================
    // Main sequence
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, ext_valid, ext_space, ext_addr, ext_internal} = '0;
        lfsr = 32'd84142;
        reset_n = 1'b0;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        // Unmapped write first, so the reset reads also show that it landed nowhere.
        apb(1'b1, 8'h10, 32'hFFFFFFFF);
        for (int i = 0; i < NUM_AREAS; i++)
        begin
            regs[i] = 24'h000000;
            apb(1'b0, PADDR_W'(4 * i), 32'h00000000);
            check("reset value", rd_data, 32'h00000000);
        end
        check("reset pins", pins, 4'hF);
        apb(1'b0, 8'h10, 32'h00000000);
        check("unmapped data", rd_data, 32'h00000000);
        check("unmapped error", rd_err, 1'b1);
        $display("reset and unmapped done");
        for (int r = 0; r < 6; r++)
        begin
            for (int i = 0; i < NUM_AREAS; i++)
            begin
                lfsr = next_rand(lfsr);
                d = {8'h00, lfsr[23:12], (r == 0) ? 4'h0 : lfsr[11:8], lfsr[7:2], 2'h0};
                d[1:0] = (r[0] ^ i[0]) ? TYPE_DRAM : TYPE_SRAM;
                apb(1'b1, PADDR_W'(4 * i), d);
                regs[i] = d[23:0] & REG_WRITE_MASK;
                apb(1'b0, PADDR_W'(4 * i), 32'h00000000);
                check("readback", {rd_err, rd_data[30:0]}, {8'h00, regs[i]});
            end
            access(60);
            $display("round %0d done", r);
        end
        // One more edge lets the memory model count the last access of the final round.
        @(posedge clk);
        check("dram cycles", dram_cycles, dram_expected);
        close_out();
    end
endmodule
